// >>> gifw_top.sv
// Port interrupt enable-clear, pending flags and wake enable behind Wishbone
// Functional notes
// - Each one written to enable-clear forces that pin's interrupt enable to zero.
// - Zeros written to enable-clear leave the matching enable bits alone.
// - Pending status reads one per pending pin; read-only, resets to zero.
// - Only pending-clear ones remove a flag; writes to status clear nothing.
// - A one written to pending-clear clears that pin's pending flag unless the pin triggers in the same cycle.
// - Zeros written to pending-clear leave pending flags unaffected.
// - Wake enable one lets the pin wake the chip; zero blocks; resets zero.
// - Trigger kind zero is level sensitive, one is edge sensitive.
// - Polarity zero picks low or falling, one picks high or rising.
// - With edge kind, both-edge bit makes either edge trigger and ignores polarity.
// - Clearing an interrupt enable never clears the pin's pending flag.
`timescale 1ns/10ps
module gifw_top #(
    parameter int unsigned NPINS = 32
)
(
    input  wire logic                          clk_i,     // 50 MHz clock
    input  wire logic                          rst_i,     // Sync reset, active high
    input  wire logic                          wb_cyc_i,  // Wishbone cycle
    input  wire logic                          wb_stb_i,  // Wishbone strobe
    input  wire logic                          wb_we_i,   // Wishbone write
    input  wire logic [gifw_pkg::ADDR_W-1:0]   wb_adr_i,  // Byte address
    input  wire logic [gifw_pkg::SEL_W-1:0]    wb_sel_i,  // Byte selects
    input  wire logic [gifw_pkg::DATA_W-1:0]   wb_dat_i,  // Write data
    output logic      [gifw_pkg::DATA_W-1:0]   wb_dat_o,  // Read data
    output logic                               wb_ack_o,  // Acknowledge
    input  wire logic [NPINS-1:0]              pins_i,    // Port pin levels
    output logic                               intr_o,    // Port interrupt
    output logic                               wake_o,    // Wake request
    output logic                               irq_o      // Block event interrupt
);
    import gifw_pkg::*;

    if (NPINS < 1 || NPINS > MAX_PINS)
    begin : g_bad_pins
        $error("gifw_top: NPINS must be 1 to 32");
    end

    typedef struct packed {
        logic [NPINS-1:0] kind;
        logic [NPINS-1:0] pol;
        logic [NPINS-1:0] both;
        logic [NPINS-1:0] en;
        logic [NPINS-1:0] pend;
        logic [NPINS-1:0] wake;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] emask;
        logic             intr;
        logic             wake_req;
        logic             irq;
    } gifw_core_t;

    gifw_bus_if       bus ();
    gifw_core_t       q;
    gifw_core_t       d;
    logic [NPINS-1:0] trig;
    logic [DATA_W-1:0] wbits;
    logic [NPINS-1:0] pin_bits;
    logic             wr_en_clr;
    logic             wr_pend_clr;
    logic             wr_pend_stat;
    logic [NPINS-1:0] en_clr;
    logic [NPINS-1:0] pend_clr;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    gifw_wb_slave u_slave (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .bus      (bus)
    );

    gifw_trigger #(
        .NPINS (NPINS)
    ) u_trig (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pins_i (pins_i),
        .kind_i (q.kind),
        .pol_i  (q.pol),
        .both_i (q.both),
        .trig_o (trig)
    );

    // Strobe registers honour byte selects like the plain ones
    assign wbits        = bus.wdata & gifw_sel_mask(bus.sel);
    assign pin_bits     = wbits[NPINS-1:0];
    assign wr_en_clr    = bus.wr_stb && (bus.addr == OFF_EN_CLEAR);
    assign wr_pend_clr  = bus.wr_stb && (bus.addr == OFF_PEND_CLR);
    assign wr_pend_stat = bus.wr_stb && (bus.addr == OFF_PEND_STAT);
    assign en_clr       = wr_en_clr ? pin_bits : '0;
    assign pend_clr     = wr_pend_clr ? pin_bits : '0;
    assign evt_clr      = (bus.wr_stb && (bus.addr == OFF_EVT_STAT)) ? wbits[EVT_W-1:0] : RST_EVT;

    always_comb
    begin
        evt_set               = RST_EVT;
        evt_set[EVT_PEND_POS] = |(trig & ~q.pend);
        evt_set[EVT_WAKE_POS] = |(trig & q.wake) & ~q.wake_req;
    end

    always_comb
    begin
        d = q;
        if (bus.wr_stb)
        begin
            unique case (bus.addr)
                OFF_TRIG_KIND: d.kind  = NPINS'(gifw_merge(32'(q.kind), bus.wdata, bus.sel));
                OFF_TRIG_POL:  d.pol   = NPINS'(gifw_merge(32'(q.pol), bus.wdata, bus.sel));
                OFF_BOTH_EDGE: d.both  = NPINS'(gifw_merge(32'(q.both), bus.wdata, bus.sel));
                OFF_INTR_EN:   d.en    = NPINS'(gifw_merge(32'(q.en), bus.wdata, bus.sel));
                OFF_WAKE_EN:   d.wake  = NPINS'(gifw_merge(32'(q.wake), bus.wdata, bus.sel));
                OFF_EVT_MASK:  d.emask = EVT_W'(gifw_merge(32'(q.emask), bus.wdata, bus.sel));
                default:       d.kind  = q.kind;
            endcase
        end
        d.en       = d.en & ~en_clr;
        // Set beats clear; enable and status writes never touch flags
        d.pend     = (q.pend & ~pend_clr) | trig;
        d.evt      = (q.evt & ~evt_clr) | evt_set;
        d.intr     = |(q.pend & q.en);
        d.wake_req = |(trig & q.wake);
        d.irq      = |(q.evt & q.emask);
    end

    // Clear strobes and unmapped words read as zero
    always_comb
    begin
        unique case (bus.addr)
            OFF_TRIG_KIND: bus.rdata = 32'(q.kind);
            OFF_TRIG_POL:  bus.rdata = 32'(q.pol);
            OFF_BOTH_EDGE: bus.rdata = 32'(q.both);
            OFF_INTR_EN:   bus.rdata = 32'(q.en);
            OFF_PEND_STAT: bus.rdata = 32'(q.pend);
            OFF_WAKE_EN:   bus.rdata = 32'(q.wake);
            OFF_EVT_STAT:  bus.rdata = 32'(q.evt);
            OFF_EVT_MASK:  bus.rdata = 32'(q.emask);
            default:       bus.rdata = RD_ZERO;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign intr_o = q.intr;
    assign wake_o = q.wake_req;
    assign irq_o  = q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_enclr_forces_zero: assert property (
        wr_en_clr |=> ((q.en & $past(pin_bits)) == '0))
        else $error("enable bit survived an enable-clear write");

    a_enclr_zero_keeps: assert property (
        (wr_en_clr && !$past(rst_i)) |=> ((q.en & ~$past(pin_bits)) == ($past(q.en) & ~$past(pin_bits))))
        else $error("enable-clear zero bit changed an enable");

    a_status_write_inert: assert property (
        (wr_pend_stat && !wr_pend_clr) |=> (($past(q.pend) & ~q.pend) == '0))
        else $error("status write cleared a pending flag");

    a_pend_clear_hits: assert property (
        wr_pend_clr |=> ((q.pend & $past(pin_bits) & ~$past(trig)) == '0))
        else $error("pending-clear one left a flag set");

    a_pend_only_by_clr: assert property (
        ##1 (($past(q.pend) & ~q.pend & ~$past(pend_clr)) == '0))
        else $error("pending flag fell without a clear");

    a_enclr_keeps_pend: assert property (
        (wr_en_clr && !wr_pend_clr) |=> (($past(q.pend) & ~q.pend) == '0))
        else $error("enable clear dropped a pending flag");

    a_level_sets_pend: assert property (
        (!q.kind[0] && (pins_i[0] == q.pol[0])) |=> q.pend[0])
        else $error("matching level did not set pending");

    a_level_off_quiet: assert property (
        (!q.kind[0] && (pins_i[0] != q.pol[0])) |-> !trig[0])
        else $error("level of wrong polarity triggered");

    a_both_edge_fire: assert property (
        (q.kind[0] && q.both[0] && !$past(rst_i, 2) && !$past(rst_i) && (pins_i[0] != $past(pins_i[0])))
        |-> trig[0])
        else $error("both-edge pin missed an edge");

    a_wake_follows: assert property (
        (|(trig & q.wake)) |=> wake_o)
        else $error("enabled trigger gave no wake request");

    a_wake_blocked: assert property (
        (q.wake == '0) |=> !wake_o)
        else $error("wake request with all wake bits clear");

    a_intr_gated: assert property (
        ((q.pend & q.en) == '0) ##1 ((q.pend & q.en) == '0) |-> !intr_o)
        else $error("port interrupt without enabled pending flag");

    a_ack_answers: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus request was not acknowledged");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    a_enclr_reads_zero: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i == OFF_EN_CLEAR)) |=> (wb_dat_o == RD_ZERO))
        else $error("enable-clear strobe read back nonzero");

    a_pclr_reads_zero: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i == OFF_PEND_CLR)) |=> (wb_dat_o == RD_ZERO))
        else $error("pending-clear strobe read back nonzero");

    a_status_read: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i == OFF_PEND_STAT)) |=> (wb_dat_o == 32'($past(q.pend))))
        else $error("pending status read differs from flags");

    a_wake_en_write: assert property (
        (bus.wr_stb && (bus.addr == OFF_WAKE_EN) && (bus.sel == {SEL_W{1'b1}}))
        |=> (q.wake == NPINS'($past(bus.wdata))))
        else $error("wake enable write did not land");

    a_wake_en_read: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i == OFF_WAKE_EN)) |=> (wb_dat_o == 32'($past(q.wake))))
        else $error("wake enable read differs from register");

    a_trig_sets_pend: assert property (
        (trig != '0) |=> ((q.pend & $past(trig)) == $past(trig)))
        else $error("trigger did not set its pending flag");

    a_intr_raised: assert property (
        ((q.pend & q.en) != '0) |=> intr_o)
        else $error("enabled pending flag gave no interrupt");

    a_level_low_fires: assert property (
        (!q.kind[0] && !q.pol[0] && !pins_i[0]) |-> trig[0])
        else $error("low level did not trigger");

    a_rise_edge_fires: assert property (
        (q.kind[0] && !q.both[0] && q.pol[0] && !$past(rst_i) && !$past(pins_i[0]) && pins_i[0]) |-> trig[0])
        else $error("rising edge missed");

    a_fall_edge_fires: assert property (
        (q.kind[0] && !q.both[0] && !q.pol[0] && !$past(rst_i) && $past(pins_i[0]) && !pins_i[0]) |-> trig[0])
        else $error("falling edge missed");

    a_rise_ignored: assert property (
        (q.kind[0] && !q.both[0] && !q.pol[0] && !$past(pins_i[0]) && pins_i[0]) |-> !trig[0])
        else $error("rising edge fired in falling mode");

    a_edge_steady_quiet: assert property (
        (q.kind[0] && (pins_i[0] == $past(pins_i[0]))) |-> !trig[0])
        else $error("edge mode fired on a steady pin");

    a_evt_pend_set: assert property (
        (|(trig & ~q.pend)) |=> q.evt[EVT_PEND_POS])
        else $error("new pending flag raised no event");

    a_evt_wake_set: assert property (
        ((|(trig & q.wake)) && !wake_o) |=> q.evt[EVT_WAKE_POS])
        else $error("wake request rise raised no event");

    a_evt_clear: assert property (
        (bus.wr_stb && (bus.addr == OFF_EVT_STAT) && bus.sel[0] && bus.wdata[EVT_PEND_POS] && !(|(trig & ~q.pend)))
        |=> !q.evt[EVT_PEND_POS])
        else $error("event status bit survived its clear");

    a_irq_follows: assert property (
        ((q.evt & q.emask) != '0) |=> irq_o)
        else $error("unmasked event gave no interrupt");

    a_irq_quiet: assert property (
        ((q.evt & q.emask) == '0) |=> !irq_o)
        else $error("event interrupt without unmasked event");

    c_edge_fired:     cover property (q.kind[0] && trig[0]);
    c_enable_cleared: cover property (wr_en_clr ##1 (q.en == '0));
    c_pend_cleared:   cover property ((q.pend != '0) ##1 wr_pend_clr ##1 (q.pend == '0));
    c_wake_raised:    cover property (!wake_o ##1 wake_o);
    c_irq_raised:     cover property (!irq_o ##1 irq_o);

endmodule

// >>> gifw_pkg.sv
// Shared constants, register map and helpers of the port interrupt/wake block
package gifw_pkg;

    // Bus geometry
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned MAX_PINS = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_TRIG_KIND = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_TRIG_POL  = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_INTR_EN   = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_EN_CLEAR  = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_PEND_STAT = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_PEND_CLR  = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_WAKE_EN   = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_BOTH_EDGE = 8'h5C;
    localparam logic [ADDR_W-1:0] OFF_EVT_STAT  = 8'h70;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h74;

    // Reset values
    localparam logic [DATA_W-1:0] RST_REG  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

    // Block event status / mask layout
    localparam int unsigned        EVT_W        = 2;
    localparam int unsigned        EVT_PEND_POS = 0;
    localparam int unsigned        EVT_WAKE_POS = 1;
    localparam logic [EVT_W-1:0]   RST_EVT      = 2'h0;

    // Byte enables widened to a bit mask
    function automatic logic [DATA_W-1:0] gifw_sel_mask(input logic [SEL_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = RD_ZERO;
        for (int i = 0; i < SEL_W; i++)
        begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Read-modify of a plain read/write register under byte enables
    function automatic logic [DATA_W-1:0] gifw_merge(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] wdata,
                                                     input logic [SEL_W-1:0]  sel);
        logic [DATA_W-1:0] m;
        m = gifw_sel_mask(sel);
        return (old & ~m) | (wdata & m);
    endfunction

endpackage

// >>> gifw_bus_if.sv
// Internal register access channel between the bus slave and the core
`timescale 1ns/10ps
interface gifw_bus_if;
    import gifw_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [SEL_W-1:0]  sel;
    logic              wr_stb;
    logic [DATA_W-1:0] rdata;

    modport bus  (output addr, output wdata, output sel, output wr_stb, input rdata);
    modport core (input addr, input wdata, input sel, input wr_stb, output rdata);
endinterface

// >>> gifw_wb_slave.sv
// Classic Wishbone slave front end with registered ack and read data
`timescale 1ns/10ps
module gifw_wb_slave
(
    input  wire logic                          clk_i,     // System clock
    input  wire logic                          rst_i,     // Sync reset, active high
    input  wire logic                          wb_cyc_i,  // Bus cycle
    input  wire logic                          wb_stb_i,  // Strobe
    input  wire logic                          wb_we_i,   // Write enable
    input  wire logic [gifw_pkg::ADDR_W-1:0]   wb_adr_i,  // Byte address
    input  wire logic [gifw_pkg::SEL_W-1:0]    wb_sel_i,  // Byte selects
    input  wire logic [gifw_pkg::DATA_W-1:0]   wb_dat_i,  // Write data
    output logic      [gifw_pkg::DATA_W-1:0]   wb_dat_o,  // Read data
    output logic                               wb_ack_o,  // Acknowledge
    gifw_bus_if.bus                            bus        // Core access
);
    import gifw_pkg::*;

    typedef struct packed {
        logic              ack;
        logic [DATA_W-1:0] dat;
    } gifw_slv_t;

    gifw_slv_t q;
    gifw_slv_t d;
    logic      req;

    assign req        = wb_cyc_i & wb_stb_i;
    assign bus.addr   = wb_adr_i;
    assign bus.wdata  = wb_dat_i;
    assign bus.sel    = wb_sel_i;
    // Commit on the edge where the master sees ack, never earlier
    assign bus.wr_stb = req & wb_we_i & q.ack;
    assign wb_ack_o   = q.ack;
    assign wb_dat_o   = q.dat;

    always_comb
    begin
        d     = q;
        d.ack = req & ~q.ack;
        if (req & ~q.ack)
        begin
            d.dat = bus.rdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '{ack: 1'b0, dat: RST_REG};
        end
        else
        begin
            q <= d;
        end
    end

endmodule

// >>> gifw_trigger.sv
// Per-pin trigger detection: level or edge, polarity, both edges
`timescale 1ns/10ps
module gifw_trigger #(
    parameter int unsigned NPINS = 32
)
(
    input  wire logic             clk_i,   // System clock
    input  wire logic             rst_i,   // Sync reset, active high
    input  wire logic [NPINS-1:0] pins_i,  // Pin levels
    input  wire logic [NPINS-1:0] kind_i,  // 0 level, 1 edge
    input  wire logic [NPINS-1:0] pol_i,   // 0 low/falling, 1 high/rising
    input  wire logic [NPINS-1:0] both_i,  // Both edges
    output logic      [NPINS-1:0] trig_o   // Trigger seen this cycle
);
    import gifw_pkg::*;

    typedef struct packed {
        logic [NPINS-1:0] prev;
        logic             armed;
    } gifw_trg_t;

    gifw_trg_t        q;
    gifw_trg_t        d;
    logic [NPINS-1:0] rise;
    logic [NPINS-1:0] fall;
    logic [NPINS-1:0] edge_hit;
    logic [NPINS-1:0] level_hit;

    // No edges until one real sample is held, else a pin high at reset fires
    assign rise      = {NPINS{q.armed}} & pins_i & ~q.prev;
    assign fall      = {NPINS{q.armed}} & ~pins_i & q.prev;
    assign edge_hit  = (both_i & (rise | fall)) | (~both_i & ((pol_i & rise) | (~pol_i & fall)));
    assign level_hit = ~(pins_i ^ pol_i);
    assign trig_o    = (kind_i & edge_hit) | (~kind_i & level_hit);

    always_comb
    begin
        d       = q;
        d.prev  = pins_i;
        d.armed = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '{prev: '0, armed: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

endmodule

// >>> gifw_pin_model.sv
// Behavioural external circuitry driving the port pins
`timescale 1ns/10ps
module gifw_pin_model #(
    parameter int unsigned NPINS = 32
)
(
    input  wire logic             clk_i,   // System clock
    input  wire logic [NPINS-1:0] lvl_i,   // Requested levels
    output logic      [NPINS-1:0] pins_o   // Driven pin levels
);
    // Pins move only just after an edge, as the core takes them synchronous
    always_ff @(posedge clk_i)
    begin
        pins_o <= lvl_i;
    end
endmodule

// >>> tb.sv
// Self-checking bench of the port interrupt, pending and wake block
`timescale 1ns/10ps
module tb;
    import gifw_pkg::*;
    localparam int unsigned NP = 24;
    localparam logic [31:0] PM = 32'h00FF_FFFF;
    logic          clk_i, rst_i, cyc, stb, we, ack, intr, wake, irq, k, o, b;
    logic [7:0]    adr;
    logic [3:0]    sel;
    logic [31:0]   wd, rdat, r, lvl, s, n, e, c, w, x;
    logic [NP-1:0] pins;
    int            mismatches, checks, cycles, seed;
    logic [2:0]    md [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h5};
    logic [7:0]    offs [8] = '{8'h34, 8'h3C, 8'h40, 8'h48, 8'h4C, 8'h70, 8'h74, 8'h80};

    gifw_pin_model #(.NPINS(NP)) i_gifw_pin_model (.clk_i(clk_i), .lvl_i(lvl[NP-1:0]), .pins_o(pins));
    gifw_top #(.NPINS(NP)) i_gifw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pins_i(pins), .intr_o(intr), .wake_o(wake), .irq_o(irq));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic summarize();
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] ex);
        checks++;
        if (g !== ex)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, ex);
        end
    endtask

    task automatic chk_out(input logic g, input logic ex);
        chk({31'h0, g}, {31'h0, ex});
    endtask

    // Classic single cycle; holds everything until ack is sampled
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= wr;
        adr <= a;
        wd  <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (ack !== 1'b1 && t < 64);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (t >= 64)
        begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic settle(input int m);
        repeat (m) @(posedge clk_i);
    endtask

    // Expected trigger per pin for a pin move p -> q under one mode
    function automatic logic [31:0] trig(input logic [31:0] p, input logic [31:0] q,
                                         input logic kd, input logic pl, input logic be);
        logic [31:0] ed;
        ed = be ? (p ^ q) : (pl ? (~p & q) : (p & ~q));
        return (kd ? ed : (pl ? q : ~q)) & PM;
    endfunction

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        seed = 77876;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, wd} = '0;
        // Pins idle high: the reset mode is low-level and would flag every pin
        lvl = PM;
        sel = 4'hF;
        settle(16);
        rst_i <= 1'b0;
        bus(1'b1, 8'h80, PM);
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 32'h0);
            chk(r, 32'h0);
        end
        for (int i = 0; i < 10; i++)
        begin
            {k, o, b} = md[i % 5];
            s = $random(seed) & PM;
            n = $random(seed) & PM;
            e = $random(seed) & PM;
            c = $random(seed) & PM;
            w = $random(seed) & PM;
            lvl <= s;
            settle(3);
            bus(1'b1, OFF_TRIG_KIND, {32{k}} & PM);
            bus(1'b1, OFF_TRIG_POL, {32{o}} & PM);
            bus(1'b1, OFF_BOTH_EDGE, {32{b}} & PM);
            bus(1'b1, OFF_PEND_CLR, PM);
            lvl <= n;
            settle(3);
            // Level triggers re-set their flags, so the start level stays pending
            x = trig(s, s, k, o, b) | trig(s, n, k, o, b);
            bus(1'b0, OFF_PEND_STAT, 32'h0);
            chk(r, x);
            bus(1'b1, OFF_PEND_STAT, PM);
            bus(1'b0, OFF_PEND_STAT, 32'h0);
            chk(r, x);
            bus(1'b1, OFF_INTR_EN, e);
            settle(3);
            chk_out(intr, |(x & e));
            bus(1'b1, OFF_PEND_CLR, c);
            x = (x & ~c) | trig(n, n, k, o, b);
            bus(1'b0, OFF_PEND_STAT, 32'h0);
            chk(r, x);
            bus(1'b1, OFF_EN_CLEAR, c);
            bus(1'b0, OFF_INTR_EN, 32'h0);
            chk(r, e & ~c);
            bus(1'b0, OFF_PEND_STAT, 32'h0);
            chk(r, x);
            bus(1'b1, OFF_WAKE_EN, w);
            bus(1'b0, OFF_WAKE_EN, 32'h0);
            chk(r, w);
            settle(3);
            chk_out(wake, |(trig(n, n, k, o, b) & w));
        end
        bus(1'b1, OFF_WAKE_EN, 32'h0);
        bus(1'b1, OFF_TRIG_KIND, PM);
        bus(1'b1, OFF_TRIG_POL, PM);
        bus(1'b1, OFF_BOTH_EDGE, 32'h0);
        lvl <= 32'h0;
        settle(3);
        bus(1'b1, OFF_PEND_CLR, PM);
        bus(1'b1, OFF_EVT_STAT, 32'h3);
        bus(1'b1, OFF_EVT_MASK, 32'h1);
        settle(3);
        chk_out(irq, 1'b0);
        lvl <= 32'h1;
        settle(5);
        chk_out(irq, 1'b1);
        bus(1'b0, OFF_EVT_STAT, 32'h0);
        chk(r & 32'h1, 32'h1);
        bus(1'b1, OFF_EVT_MASK, 32'h0);
        settle(3);
        chk_out(irq, 1'b0);
        bus(1'b1, OFF_EVT_MASK, 32'h1);
        bus(1'b1, OFF_EVT_STAT, 32'h1);
        settle(3);
        chk_out(irq, 1'b0);
        summarize();
    end
endmodule
